// >>> rtl/watchdog_wake_control.sv
// Our own choices: the address map and the strobed register port.
module watchdog_wake_control #(
	parameter int PORT_A_WIDTH = 8,
	parameter int IRQ_COUNT    = 4
) (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic [1:0]              regAddr,
	input  wire logic [7:0]              regWrData,
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	output logic      [7:0]              regRdData,
	input  wire logic                    haltExec,
	input  wire logic                    clearWdtExec,
	input  wire logic                    idleSelect,
	input  wire logic                    fastWakeEnable,
	input  wire logic                    highCrystalSelect,
	input  wire logic                    lowCrystalSelect,
	input  wire logic                    sysClkOnSub,
	input  wire logic                    lowCrystalClkPin,
	input  wire logic [PORT_A_WIDTH-1:0] portAPin,
	input  wire logic [IRQ_COUNT-1:0]    irqRequest,
	input  wire logic [IRQ_COUNT-1:0]    irqEnable,
	input  wire logic                    stackFull,
	input  wire logic                    lowVoltageResetEvent,
	input  wire logic                    voltageRegResetEvent,
	output logic                         cpuRun,
	output logic                         powerDown,
	output logic                         deviceReset,
	output logic                         wakeResume,
	output logic                         wakeIrqEntry,
	output logic                         wakePcSpReset,
	output logic                         highOscEnable,
	output logic                         sysClkOnLowRc,
	output logic                         subClkRun,
	output logic                         periphClkOnSub
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	localparam int WDT_COUNT_WIDTH_L = wdt_wake_pkg::WDT_COUNT_WIDTH;

	wdt_wake_pkg::power_state_type state_reg;
	wdt_wake_pkg::power_state_type state_next;

	logic [PORT_A_WIDTH-1:0] portASync1_reg;
	logic [PORT_A_WIDTH-1:0] portASync2_reg;
	logic [PORT_A_WIDTH-1:0] portAPrev_reg;
	logic [PORT_A_WIDTH-1:0] portAWakeEnable_reg;
	logic                    lowXtalSync1_reg;
	logic                    lowXtalSync2_reg;
	logic                    lowXtalPrev_reg;
	logic [11:0]             lowRcCount_reg;
	logic                    lowRcTick;
	logic                    lowXtalTick;
	logic                    subTick;
	logic [7:0]              watchdogControl_reg;
	logic                    keepOn_reg;
	logic                    lowVoltageFlag_reg;
	logic                    voltageRegFlag_reg;
	logic                    watchdogRegFlag_reg;
	logic                    badPending_reg;
	logic [1:0]              badTicks_reg;
	logic                    badReset;
	logic [WDT_COUNT_WIDTH_L-1:0] wdtCount_reg;
	logic [WDT_COUNT_WIDTH_L-1:0] wdtLast;
	logic                    wdtEnabled;
	logic                    wdtTimeout;
	logic                    powerDownFlag_reg;
	logic                    timeoutFlag_reg;
	logic                    highOscReady_reg;
	logic                    lowOscReady_reg;
	logic                    lowStartNeeded_reg;
	logic                    fastWake_reg;
	logic [11:0]             stabCount_reg;
	logic                    stabDone;
	logic [IRQ_COUNT-1:0]    irqBlocked_reg;
	logic                    sleeping;
	logic                    portAWake;
	logic                    irqWake;
	logic                    irqEntry;
	logic                    wakeEvent;
	logic                    haltTaken;
	logic                    clearTaken;
	logic                    wdtWrite;
	logic                    ctrlWrite;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; logic reads the second stage and the delayed third stage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			portASync1_reg   <= '1;
			portASync2_reg   <= '1;
			portAPrev_reg    <= '1;
			lowXtalSync1_reg <= 1'b0;
			lowXtalSync2_reg <= 1'b0;
			lowXtalPrev_reg  <= 1'b0;
		end else begin
			portASync1_reg   <= portAPin;
			portASync2_reg   <= portASync1_reg;
			portAPrev_reg    <= portASync2_reg;
			lowXtalSync1_reg <= lowCrystalClkPin;
			lowXtalSync2_reg <= lowXtalSync1_reg;
			lowXtalPrev_reg  <= lowXtalSync2_reg;
		end
	end

	// Low-speed RC tick divider from the system clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lowRcCount_reg <= 12'h000;
		end else if (lowRcCount_reg == wdt_wake_pkg::LOW_RC_DIV_LAST) begin
			lowRcCount_reg <= 12'h000;
		end else begin
			lowRcCount_reg <= lowRcCount_reg + 12'h001;
		end
	end

	// Sub clock tick: RC divider or crystal rising edge
	assign lowRcTick   = lowRcCount_reg == wdt_wake_pkg::LOW_RC_DIV_LAST;
	assign lowXtalTick = lowXtalSync2_reg & ~lowXtalPrev_reg;
	assign subTick     = lowCrystalSelect ? lowXtalTick : lowRcTick;

	////////////////////////////////////////////////////////////////////////
	// Register writes and decoded control
	assign wdtWrite   = regWrite &&
		regAddr == wdt_wake_pkg::OFF_WATCHDOG_CONTROL;
	assign ctrlWrite  = regWrite &&
		regAddr == wdt_wake_pkg::OFF_SYSTEM_RESET_FLAGS;
	assign wdtEnabled = watchdogControl_reg[wdt_wake_pkg::PATTERN_MSB:
		wdt_wake_pkg::PATTERN_LSB] != wdt_wake_pkg::PATTERN_DISABLE;
	assign subClkRun  = wdtEnabled;

	// Watchdog control; returns to power-up value on its own reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			watchdogControl_reg <= wdt_wake_pkg::WATCHDOG_CONTROL_RESET;
		end else if (badReset) begin
			watchdogControl_reg <= wdt_wake_pkg::WATCHDOG_CONTROL_RESET;
		end else if (wdtWrite) begin
			watchdogControl_reg <= regWrData;
		end
	end

	// Port A wake enables
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			portAWakeEnable_reg <= PORT_A_WIDTH'(wdt_wake_pkg::PORT_A_WAKE_RESET);
		end else if (regWrite &&
				regAddr == wdt_wake_pkg::OFF_PORT_A_WAKE_ENABLE) begin
			portAWakeEnable_reg <= regWrData[PORT_A_WIDTH-1:0];
		end
	end

	// Bad enable pattern: count RC ticks, then reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			badPending_reg <= 1'b0;
			badTicks_reg   <= 2'h0;
		end else if (badReset) begin
			badPending_reg <= 1'b0;
			badTicks_reg   <= 2'h0;
		end else if (wdtWrite) begin
			badPending_reg <= regWrData[wdt_wake_pkg::PATTERN_MSB:
				wdt_wake_pkg::PATTERN_LSB] != wdt_wake_pkg::PATTERN_DISABLE &&
				regWrData[wdt_wake_pkg::PATTERN_MSB:
				wdt_wake_pkg::PATTERN_LSB] != wdt_wake_pkg::PATTERN_ENABLE;
			badTicks_reg   <= 2'h0;
		end else if (badPending_reg && lowRcTick) begin
			badTicks_reg   <= badTicks_reg + 2'h1;
		end
	end

	// Third RC tick after the write ends 2 to 3 full periods
	assign badReset = badPending_reg && lowRcTick &&
		badTicks_reg == wdt_wake_pkg::BAD_PATTERN_TICKS - 2'h1;

	// System reset flags: hardware set wins over software clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			keepOn_reg          <= 1'b0;
			lowVoltageFlag_reg  <= 1'b0;
			voltageRegFlag_reg  <= 1'b0;
			watchdogRegFlag_reg <= 1'b0;
		end else begin
			if (ctrlWrite) begin
				keepOn_reg <= regWrData[wdt_wake_pkg::KEEP_ON_BIT];
			end
			if (lowVoltageResetEvent) begin
				lowVoltageFlag_reg <= 1'b1;
			end else if (ctrlWrite &&
					!regWrData[wdt_wake_pkg::LOW_VOLTAGE_BIT]) begin
				lowVoltageFlag_reg <= 1'b0;
			end
			if (voltageRegResetEvent) begin
				voltageRegFlag_reg <= 1'b1;
			end else if (ctrlWrite &&
					!regWrData[wdt_wake_pkg::VOLTAGE_REG_BIT]) begin
				voltageRegFlag_reg <= 1'b0;
			end
			if (badReset) begin
				watchdogRegFlag_reg <= 1'b1;
			end else if (ctrlWrite &&
					!regWrData[wdt_wake_pkg::WATCHDOG_REG_BIT]) begin
				watchdogRegFlag_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog counter and timeout
	always_comb begin
		unique case (watchdogControl_reg[wdt_wake_pkg::SELECT_MSB:0])
			3'h0: wdtLast = WDT_COUNT_WIDTH_L'(18'h000FF);
			3'h1: wdtLast = WDT_COUNT_WIDTH_L'(18'h003FF);
			3'h2: wdtLast = WDT_COUNT_WIDTH_L'(18'h00FFF);
			3'h3: wdtLast = WDT_COUNT_WIDTH_L'(18'h03FFF);
			3'h4: wdtLast = WDT_COUNT_WIDTH_L'(18'h07FFF);
			3'h5: wdtLast = WDT_COUNT_WIDTH_L'(18'h0FFFF);
			3'h6: wdtLast = WDT_COUNT_WIDTH_L'(18'h1FFFF);
			3'h7: wdtLast = WDT_COUNT_WIDTH_L'(18'h3FFFF);
		endcase
	end

	assign haltTaken  = haltExec && state_reg == wdt_wake_pkg::RUN;
	assign clearTaken = clearWdtExec && cpuRun;
	assign wdtTimeout = wdtEnabled && subTick &&
		wdtCount_reg == wdtLast;

	// Count sub ticks while enabled; clears win over counting
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wdtCount_reg <= '0;
		end else if (clearTaken) begin
			wdtCount_reg <= '0;
		end else if (haltTaken) begin
			wdtCount_reg <= '0;
		end else if (wdtTimeout || badReset || !wdtEnabled) begin
			wdtCount_reg <= '0;
		end else if (subTick) begin
			wdtCount_reg <= wdtCount_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wake sources
	assign sleeping  = state_reg == wdt_wake_pkg::DEEP_SLEEP ||
		state_reg == wdt_wake_pkg::WDT_SLEEP ||
		state_reg == wdt_wake_pkg::IDLE_OFF ||
		state_reg == wdt_wake_pkg::IDLE_ON;
	assign portAWake = |(portAPrev_reg & ~portASync2_reg &
		portAWakeEnable_reg);
	assign irqWake   = |(irqRequest & ~irqBlocked_reg);
	assign irqEntry  = |(irqRequest & ~irqBlocked_reg & irqEnable) &&
		!stackFull;
	assign wakeEvent = sleeping &&
		(portAWake || irqWake || wdtTimeout);

	// Requests already pending at halt are barred from waking
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqBlocked_reg <= '0;
		end else if (haltTaken) begin
			irqBlocked_reg <= irqRequest;
		end
	end

	// Wake cause pulses; watchdog first, then interrupt entry, then resume for pin or other interrupt
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wakeResume    <= 1'b0;
			wakeIrqEntry  <= 1'b0;
			wakePcSpReset <= 1'b0;
		end else begin
			wakePcSpReset <= wakeEvent && wdtTimeout;
			wakeIrqEntry  <= wakeEvent && !wdtTimeout && irqEntry;
			wakeResume    <= wakeEvent && !wdtTimeout &&
				!irqEntry;
		end
	end

	// Device reset: running timeout or bad enable pattern
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			deviceReset <= 1'b0;
		end else begin
			deviceReset <= badReset ||
				(wdtTimeout && !sleeping);
		end
	end

	// Power-down and timeout flags; set wins over clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			powerDownFlag_reg <= 1'b0;
			timeoutFlag_reg   <= 1'b0;
		end else begin
			if (haltTaken) begin
				powerDownFlag_reg <= 1'b1;
			end else if (clearTaken) begin
				powerDownFlag_reg <= 1'b0;
			end
			if (wdtTimeout) begin
				timeoutFlag_reg <= 1'b1;
			end else if (haltTaken) begin
				timeoutFlag_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			wdt_wake_pkg::RUN: begin
				if (haltTaken) begin
					if (idleSelect) begin
						state_next = keepOn_reg ? wdt_wake_pkg::IDLE_ON :
							wdt_wake_pkg::IDLE_OFF;
					end else begin
						state_next = wdtEnabled ? wdt_wake_pkg::WDT_SLEEP :
							wdt_wake_pkg::DEEP_SLEEP;
					end
				end
			end
			wdt_wake_pkg::DEEP_SLEEP,
			wdt_wake_pkg::WDT_SLEEP,
			wdt_wake_pkg::IDLE_OFF: begin
				if (wakeEvent) begin
					state_next = wdt_wake_pkg::WAKE_HIGH;
				end
			end
			wdt_wake_pkg::IDLE_ON: begin
				if (wakeEvent) begin
					state_next = wdt_wake_pkg::RUN;
				end
			end
			wdt_wake_pkg::WAKE_HIGH: begin
				if (stabDone) begin
					state_next = (lowCrystalSelect && lowStartNeeded_reg) ?
						wdt_wake_pkg::WAKE_LOW : wdt_wake_pkg::RUN;
				end
			end
			wdt_wake_pkg::WAKE_LOW: begin
				if (stabDone) begin
					state_next = wdt_wake_pkg::RUN;
				end
			end
			default: state_next = wdt_wake_pkg::RUN;
		endcase
	end

	// Power-up starts as a wake from the deepest sleep
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= wdt_wake_pkg::WAKE_HIGH;
		end else begin
			state_reg <= state_next;
		end
	end

	// Shared stabilise counter, restarted on each phase entry
	assign stabDone = (state_reg == wdt_wake_pkg::WAKE_HIGH &&
		stabCount_reg == wdt_wake_pkg::HIGH_STAB_CYCLES - 12'h001) ||
		(state_reg == wdt_wake_pkg::WAKE_LOW &&
		stabCount_reg == wdt_wake_pkg::LOW_STAB_CYCLES - 12'h001);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stabCount_reg <= 12'h000;
		end else if (stabDone || state_next != state_reg) begin
			stabCount_reg <= 12'h000;
		end else if (state_reg == wdt_wake_pkg::WAKE_HIGH ||
				state_reg == wdt_wake_pkg::WAKE_LOW) begin
			stabCount_reg <= stabCount_reg + 12'h001;
		end
	end

	// Oscillator ready flags and crystal restart need
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			highOscReady_reg   <= 1'b0;
			lowOscReady_reg    <= 1'b0;
			lowStartNeeded_reg <= 1'b1;
		end else if (haltTaken && !(idleSelect && keepOn_reg)) begin
			highOscReady_reg   <= 1'b0;
			lowStartNeeded_reg <= !wdtEnabled && !idleSelect;
			if (!wdtEnabled && !idleSelect) begin
				lowOscReady_reg <= 1'b0;
			end
		end else if (stabDone &&
				state_reg == wdt_wake_pkg::WAKE_HIGH) begin
			highOscReady_reg <= 1'b1;
			if (!(lowCrystalSelect && lowStartNeeded_reg)) begin
				lowOscReady_reg <= 1'b1;
			end
		end else if (stabDone) begin
			lowOscReady_reg    <= 1'b1;
			lowStartNeeded_reg <= 1'b0;
		end
	end

	// Fast wake: watchdog sleep, high crystal, enable set
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fastWake_reg <= 1'b0;
		end else if (wakeEvent) begin
			fastWake_reg <= state_reg == wdt_wake_pkg::WDT_SLEEP &&
				highCrystalSelect && fastWakeEnable;
		end else if (state_reg == wdt_wake_pkg::RUN) begin
			fastWake_reg <= 1'b0;
		end
	end

	// Core and clock status outputs
	assign sysClkOnLowRc = fastWake_reg &&
		state_reg == wdt_wake_pkg::WAKE_HIGH;
	assign cpuRun        = state_reg == wdt_wake_pkg::RUN ||
		state_reg == wdt_wake_pkg::WAKE_LOW || sysClkOnLowRc;
	assign powerDown     = sleeping;
	assign highOscEnable = !(state_reg == wdt_wake_pkg::DEEP_SLEEP ||
		state_reg == wdt_wake_pkg::WDT_SLEEP ||
		state_reg == wdt_wake_pkg::IDLE_OFF);

	// Peripheral clock source tracks the system clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periphClkOnSub <= 1'b0;
		end else begin
			periphClkOnSub <= sysClkOnSub || sysClkOnLowRc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, valid the cycle after the read strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			unique case (regAddr)
				wdt_wake_pkg::OFF_WATCHDOG_CONTROL:
					regRdData <= watchdogControl_reg;
				wdt_wake_pkg::OFF_SYSTEM_RESET_FLAGS:
					regRdData <= {keepOn_reg, 4'h0, lowVoltageFlag_reg,
						voltageRegFlag_reg, watchdogRegFlag_reg};
				wdt_wake_pkg::OFF_PORT_A_WAKE_ENABLE:
					regRdData <= 8'(portAWakeEnable_reg);
				wdt_wake_pkg::OFF_POWER_STATUS:
					regRdData <= {4'h0, lowOscReady_reg, highOscReady_reg,
						timeoutFlag_reg, powerDownFlag_reg};
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

endmodule

// >>> rtl/wdt_wake_pkg.sv
package wdt_wake_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets on the plain register port
	localparam int          ADDR_WIDTH             = 2;
	localparam logic [1:0]  OFF_WATCHDOG_CONTROL   = 2'h0;
	localparam logic [1:0]  OFF_SYSTEM_RESET_FLAGS = 2'h1;
	localparam logic [1:0]  OFF_PORT_A_WAKE_ENABLE = 2'h2;
	localparam logic [1:0]  OFF_POWER_STATUS       = 2'h3;

	// Values after power-up
	localparam logic [7:0]  WATCHDOG_CONTROL_RESET = 8'h53;
	localparam logic [7:0]  PORT_A_WAKE_RESET      = 8'h00;

	// Watchdog control fields
	localparam int          PATTERN_MSB            = 7;
	localparam int          PATTERN_LSB            = 3;
	localparam int          SELECT_MSB             = 2;
	localparam logic [4:0]  PATTERN_DISABLE        = 5'h15;
	localparam logic [4:0]  PATTERN_ENABLE         = 5'h0A;

	// System reset flags fields
	localparam int          KEEP_ON_BIT            = 7;
	localparam int          LOW_VOLTAGE_BIT        = 2;
	localparam int          VOLTAGE_REG_BIT        = 1;
	localparam int          WATCHDOG_REG_BIT       = 0;

	// Power status fields (read only)
	localparam int          POWER_DOWN_BIT         = 0;
	localparam int          TIMEOUT_BIT            = 1;
	localparam int          HIGH_READY_BIT         = 2;
	localparam int          LOW_READY_BIT          = 3;

	////////////////////////////////////////////////////////////////////////
	// Timing: system clock and low-speed RC tick divider
	localparam int          SYS_CLK_HZ             = 125_000_000;
	localparam int          LOW_RC_HZ              = 32_000;
	localparam logic [11:0] LOW_RC_DIV_LAST        =
		12'(SYS_CLK_HZ / LOW_RC_HZ - 1);
	localparam logic [1:0]  BAD_PATTERN_TICKS      = 2'h3;
	localparam logic [11:0] HIGH_STAB_CYCLES       = 12'h400;
	localparam logic [11:0] LOW_STAB_CYCLES        = 12'h800;
	localparam int          WDT_COUNT_WIDTH        = 18;

	// Power state, Gray along deep sleep -> wake high -> wake low -> run
	typedef enum logic [2:0] {
		RUN        = 3'h0,
		DEEP_SLEEP = 3'h1,
		WAKE_HIGH  = 3'h3,
		WAKE_LOW   = 3'h2,
		WDT_SLEEP  = 3'h5,
		IDLE_OFF   = 3'h4,
		IDLE_ON    = 3'h6
	} power_state_type;

endpackage

// >>> testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
	logic       haltExec = 1'b0, clearWdtExec = 1'b0, stackFull = 1'b0;
	logic       idleSelect = 1'b0, fastWakeEnable = 1'b0, sysClkOnSub = 1'b0;
	logic       highCrystalSelect = 1'b0, lowCrystalSelect = 1'b1;
	logic       lowCrystalClkPin = 1'b0, lowVoltageResetEvent = 1'b0;
	logic       voltageRegResetEvent = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWrData = 8'h00, portAPin = 8'hFF, regRdData, v;
	logic [3:0] irqRequest = 4'h0, irqEnable = 4'h0;
	logic       cpuRun, powerDown, deviceReset, wakeResume, wakeIrqEntry;
	logic       wakePcSpReset, highOscEnable, sysClkOnLowRc, subClkRun;
	logic       periphClkOnSub;
	int         num_errors = 0, n_checks = 0, cyc = 0, n;

	// Device, ports matched by name
	watchdog_wake_control u_dut (.*);

	// System clock, crystal pin ticking every 8 cycles
	always #4 clk = ~clk;
	always #32 lowCrystalClkPin = ~lowCrystalClkPin;

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			num_errors++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Bus and pulse helpers
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = regRdData;
	endtask
	task automatic halt();
		@(posedge clk);
		haltExec <= 1'b1;
		@(posedge clk);
		haltExec <= 1'b0;
		#1;
	endtask
	task automatic clr();
		@(posedge clk);
		clearWdtExec <= 1'b1;
		@(posedge clk);
		clearWdtExec <= 1'b0;
	endtask
	task automatic rst();
		@(posedge clk);
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (3200) @(posedge clk);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return deviceReset;
			1: return wakeResume;
			2: return wakeIrqEntry;
			default: return wakePcSpReset;
		endcase
	endfunction
	task automatic waitOn(input int s, lim, output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (sig(s) !== 1'b1 && k < lim);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		rd(2'h0, v);
		chk("control reset", v, 8'h53);
		@(posedge clk);
		lowVoltageResetEvent <= 1'b1;
		@(posedge clk);
		lowVoltageResetEvent <= 1'b0;
		wr(2'h1, 8'hFF);
		rd(2'h1, v);
		chk("flags all ones", v, 8'h84);
		wr(2'h1, 8'h00);
		rd(2'h1, v);
		chk("flags cleared", v, 8'h00);
		wr(2'h0, 8'hA8);
		chk("sub clock off", 8'(subClkRun), 8'h00);
		wr(2'h0, 8'h53);
		chk("sub clock on", 8'(subClkRun), 8'h01);
	endtask

	task automatic t_wdt(input int c);
		int e;
		e = (c != 0 ? 1024 : 256) * 8;
		rst();
		wr(2'h0, {5'h0A, 3'(c)});
		clr();
		waitOn(0, e + 40, n);
		chk("period", 8'(n > e - 24 && deviceReset), 8'h01);
		rd(2'h3, v);
		chk("timeout flag", 8'(v[1]), 8'h01);
	endtask

	task automatic t_sleep();
		rst();
		wr(2'h0, 8'h50);
		wr(2'h2, 8'h01);
		halt();
		chk("asleep", 8'(powerDown), 8'h01);
		rd(2'h3, v);
		chk("pdf set", 8'(v[1:0]), 8'h01);
		@(posedge clk);
		portAPin <= 8'hFD;
		repeat (16) @(posedge clk);
		#1;
		chk("masked pin", 8'(powerDown), 8'h01);
		@(posedge clk);
		portAPin <= 8'hFC;
		waitOn(1, 10, n);
		chk("pin wake", 8'(wakeResume), 8'h01);
		@(posedge clk);
		portAPin <= 8'hFF;
		repeat (1100) @(posedge clk);
		halt();
		waitOn(3, 2100, n);
		chk("sleep timeout", 8'(n > 2024 && wakePcSpReset), 8'h01);
		rd(2'h3, v);
		chk("sleep flags", 8'(v[1:0]), 8'h03);
		repeat (1100) @(posedge clk);
		clr();
		rd(2'h3, v);
		chk("pdf cleared", 8'(v[0]), 8'h00);
	endtask

	task automatic t_irq();
		int i;
		rst();
		@(posedge clk);
		irqRequest <= 4'h1;
		irqEnable <= 4'h3;
		halt();
		repeat (20) @(posedge clk);
		#1;
		chk("old request", 8'(powerDown), 8'h01);
		@(posedge clk);
		irqRequest <= 4'h3;
		waitOn(2, 10, n);
		chk("irq entry", 8'(wakeIrqEntry), 8'h01);
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			irqRequest <= 4'h0;
			stackFull <= (i == 0);
			repeat (1100) @(posedge clk);
			halt();
			@(posedge clk);
			irqRequest <= (i != 0) ? 4'h4 : 4'h2;
			waitOn(1, 10, n);
			chk("irq resume", 8'(wakeResume), 8'h01);
		end
	endtask

	// Deep sleep, fast wake, idle-on and peripheral clock source
	task automatic t_modes();
		rst();
		sysClkOnSub <= 1'b1;
		wr(2'h2, 8'h01);
		chk("periph on sub", 8'(periphClkOnSub), 8'h01);
		wr(2'h0, 8'hA8);
		halt();
		chk("high osc off", 8'(highOscEnable), 8'h00);
		@(posedge clk);
		portAPin <= 8'hFE;
		waitOn(1, 10, n);
		chk("deep wake held", 8'(cpuRun), 8'h00);
		repeat (1030) @(posedge clk);
		rd(2'h3, v);
		chk("crystal after high", v, 8'h05);
		repeat (2100) @(posedge clk);
		rd(2'h3, v);
		chk("both ready", v, 8'h0D);
		@(posedge clk);
		portAPin <= 8'hFF;
		sysClkOnSub <= 1'b0;
		highCrystalSelect <= 1'b1;
		fastWakeEnable <= 1'b1;
		wr(2'h0, 8'h53);
		chk("periph off sub", 8'(periphClkOnSub), 8'h00);
		halt();
		@(posedge clk);
		portAPin <= 8'hFE;
		waitOn(1, 10, n);
		chk("fast wake", 8'({sysClkOnLowRc, cpuRun}), 8'h03);
		repeat (1100) @(posedge clk);
		portAPin <= 8'hFF;
		idleSelect <= 1'b1;
		wr(2'h1, 8'h80);
		halt();
		chk("idle entered", 8'(powerDown), 8'h01);
		@(posedge clk);
		portAPin <= 8'hFE;
		waitOn(1, 10, n);
		chk("idle wake", 8'({wakeResume, cpuRun}), 8'h03);
	endtask

	task automatic t_bad();
		rst();
		wr(2'h0, 8'hFB);
		waitOn(0, 12000, n);
		chk("bad delay", 8'(n >= 7800 && n <= 11730), 8'h01);
		rd(2'h1, v);
		chk("wrf set", v, 8'h01);
		rd(2'h0, v);
		chk("control back", v, 8'h53);
		wr(2'h1, 8'h01);
		rd(2'h1, v);
		chk("wrf kept", v, 8'h01);
		wr(2'h1, 8'h00);
		rd(2'h1, v);
		chk("wrf cleared", v, 8'h00);
	endtask

	// Main sequence
	initial begin
		rst();
		t_regs();
		t_wdt(0);
		t_wdt(1);
		t_sleep();
		t_irq();
		t_modes();
		t_bad();
		results();
	end
endmodule

// >>> testbench/wdt_wake_sva.sv
module wdt_wake_sva #(
	parameter int IRQ_COUNT = 4
) (
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic [1:0]           regAddr,
	input wire logic [7:0]           regWrData,
	input wire logic                 regWrite,
	input wire logic                 regRead,
	input wire logic [7:0]           regRdData,
	input wire logic                 haltExec,
	input wire logic                 idleSelect,
	input wire logic [IRQ_COUNT-1:0] irqRequest,
	input wire logic [IRQ_COUNT-1:0] irqEnable,
	input wire logic                 stackFull,
	input wire logic                 cpuRun,
	input wire logic                 powerDown,
	input wire logic                 deviceReset,
	input wire logic                 wakeResume,
	input wire logic                 wakeIrqEntry,
	input wire logic                 wakePcSpReset,
	input wire logic                 subClkRun
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////
	// Wake cause pulses and their preconditions
	sequence s_wake;
		wakeResume || wakeIrqEntry || wakePcSpReset;
	endsequence
	property p_wake_onehot;
		$onehot0({wakeResume, wakeIrqEntry, wakePcSpReset});
	endproperty
	property p_wake_from_pd;
		s_wake |-> $past(powerDown);
	endproperty
	property p_halt_enters;
		$rose(powerDown) |-> $past(haltExec);
	endproperty
	property p_pd_stops_cpu;
		powerDown && !idleSelect |-> !cpuRun;
	endproperty
	property p_rst_pulse;
		deviceReset |=> !deviceReset;
	endproperty
	property p_pcsp_soft;
		wakePcSpReset |-> !deviceReset ##1 !deviceReset;
	endproperty
	property p_irq_entry;
		wakeIrqEntry |-> |($past(irqRequest) & $past(irqEnable))
			&& !$past(stackFull);
	endproperty
	property p_disable;
		regWrite && regAddr == 2'h0 && regWrData[7:3] == 5'h15
			|=> !subClkRun;
	endproperty
	property p_flags_gap;
		regRead && regAddr == 2'h1 |=> regRdData[6:3] == 4'h0;
	endproperty

	a_wake_onehot: assert property (p_wake_onehot)
		else $error("more than one wake cause");
	a_wake_from_pd: assert property (p_wake_from_pd)
		else $error("wake pulse while awake");
	a_halt_enters: assert property (p_halt_enters)
		else $error("power-down without halt");
	a_pd_stops_cpu: assert property (p_pd_stops_cpu)
		else $error("core runs in sleep");
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("device reset longer than one cycle");
	a_pcsp_soft: assert property (p_pcsp_soft)
		else $error("sleep timeout gave full reset");
	a_irq_entry: assert property (p_irq_entry)
		else $error("interrupt entry without enabled request");
	a_disable: assert property (p_disable)
		else $error("sub clock runs after disable");
	a_flags_gap: assert property (p_flags_gap)
		else $error("flag bits 6 to 3 not zero");
endmodule

bind watchdog_wake_control wdt_wake_sva #(.IRQ_COUNT(IRQ_COUNT)) u_sva (.*);
